// File: timer8_pkg.sv
/*
 * Constants for the 8-bit timer waveform and compare-output block.
 * Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word.
 */
package timer8_pkg;

	// Register byte offsets
	localparam logic [4:0] OFS_OUT_MODE  = 5'h00;
	localparam logic [4:0] OFS_CLK_MODE  = 5'h04;
	localparam logic [4:0] OFS_COUNTER   = 5'h08;
	localparam logic [4:0] OFS_CMP_A     = 5'h0C;
	localparam logic [4:0] OFS_CMP_B     = 5'h10;
	localparam logic [4:0] OFS_FLAGS     = 5'h14;
	localparam logic [4:0] OFS_PIN_CTRL  = 5'h18;

	// Field positions
	localparam int CHA_MODE_LSB  = 6;
	localparam int CHB_MODE_LSB  = 4;
	localparam int WAVE_LO_LSB   = 0;
	localparam int WAVE_HI_BIT   = 3;
	localparam int FLAG_MATCH_B  = 3;
	localparam int FLAG_MATCH_A  = 2;
	localparam int FLAG_OVF      = 1;
	localparam int PIN_DIR_A     = 0;
	localparam int PIN_DIR_B     = 1;
	localparam int PIN_PORT_A    = 4;
	localparam int PIN_PORT_B    = 5;

	// Writable masks; reserved bits read zero
	localparam logic [7:0] OUT_MODE_MASK = 8'hF3;
	localparam logic [7:0] CLK_MODE_MASK = 8'h0F;
	localparam logic [7:0] PIN_CTRL_MASK = 8'h33;

	// Reset values and counter limits
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] CNT_MAX   = 8'hFF;
	localparam logic [7:0] CNT_BOT   = 8'h00;

	// Output action codes
	localparam logic [1:0] ACT_OFF    = 2'b00;
	localparam logic [1:0] ACT_TOGGLE = 2'b01;
	localparam logic [1:0] ACT_CLEAR  = 2'b10;
	localparam logic [1:0] ACT_SET    = 2'b11;

	// Waveform modes, three-bit code
	typedef enum logic [2:0] {
		MODE_NORMAL  = 3'b000,
		MODE_PC_FF   = 3'b001,
		MODE_CTC     = 3'b010,
		MODE_FAST_FF = 3'b011,
		MODE_RSV4    = 3'b100,
		MODE_PC_CA   = 3'b101,
		MODE_RSV6    = 3'b110,
		MODE_FAST_CA = 3'b111
	} wave_mode_t;

endpackage : timer8_pkg

// File: timer8_waveform_mode_control.sv
/*
 * 8-bit timer with two compare channels, waveform modes and Avalon-MM registers.
 * Assumes i_timer_tick_enable is a one-cycle pulse from a prescaler on i_clk_sys.
 */
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps

module timer8_waveform_mode_control
	import timer8_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_nrst,
	// Prescaled tick
	input  wire logic        i_timer_tick_enable,
	// Avalon-MM slave
	input  wire logic [4:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	// Pins
	output logic             o_pin_a,
	output logic             o_pin_a_oe,
	output logic             o_pin_b,
	output logic             o_pin_b_oe
);

	// Next output state for one channel on a match or at TOP
	function automatic logic chan_next(input logic cur, input logic [1:0] code,
		input logic pwm, input logic pc, input logic toggle_ok, input logic up,
		input logic match, input logic top_evt);
		logic v;
		v = cur;
		if (!pwm) begin
			if (match) begin
				case (code)
					ACT_TOGGLE: v = ~cur;
					ACT_CLEAR:  v = 1'b0;
					ACT_SET:    v = 1'b1;
					default:    v = cur;
				endcase
			end
		end else begin
			if (match) begin
				case (code)
					ACT_TOGGLE: v = toggle_ok ? ~cur : cur;
					ACT_CLEAR:  v = (pc && !up) ? 1'b1 : 1'b0;
					ACT_SET:    v = (pc && !up) ? 1'b0 : 1'b1;
					default:    v = cur;
				endcase
			end
			// TOP action matches a down-count result so both slopes stay symmetric
			if (top_evt && code[1]) begin
				v = (code == ACT_CLEAR);
			end
		end
		return v;
	endfunction : chan_next

	// Reset release
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Register and timer state
	logic [7:0]  out_mode_r,  out_mode_nxt;
	logic [7:0]  clk_mode_r,  clk_mode_nxt;
	logic [7:0]  cnt_r,       cnt_nxt;
	logic [7:0]  cmp_buf_a_r, cmp_buf_a_nxt;
	logic [7:0]  cmp_buf_b_r, cmp_buf_b_nxt;
	logic [7:0]  cmp_act_a_r, cmp_act_a_nxt;
	logic [7:0]  cmp_act_b_r, cmp_act_b_nxt;
	logic [3:1]  flags_r,     flags_nxt;
	logic [7:0]  pin_ctrl_r,  pin_ctrl_nxt;
	logic        up_r,        up_nxt;
	logic        block_r,     block_nxt;
	logic        out_a_r,     out_a_nxt;
	logic        out_b_r,     out_b_nxt;
	logic        pin_a_r,     pin_a_nxt;
	logic        pin_b_r,     pin_b_nxt;
	logic        wait_r,      wait_nxt;
	logic [31:0] rdata_r,     rdata_nxt;

	wave_mode_t  mode;
	logic        tick;
	logic        pwm;
	logic        pc;
	logic        fast;
	logic [7:0]  top;
	logic        at_top;
	logic        match_a;
	logic        match_b;
	logic        ovf;
	logic        wr_en;
	logic [1:0]  code_a;
	logic [1:0]  code_b;

	always_comb begin
		mode   = wave_mode_t'({clk_mode_r[WAVE_HI_BIT],
			out_mode_r[WAVE_LO_LSB +: 2]});
		code_a = out_mode_r[CHA_MODE_LSB +: 2];
		code_b = out_mode_r[CHB_MODE_LSB +: 2];
		// Counting stops while the clock-select field is zero
		tick   = i_timer_tick_enable && (clk_mode_r[2:0] != 3'b000);
		pc     = (mode == MODE_PC_FF) || (mode == MODE_PC_CA);
		fast   = (mode == MODE_FAST_FF) || (mode == MODE_FAST_CA);
		pwm    = pc || fast;
		case (mode)
			MODE_CTC, MODE_PC_CA, MODE_FAST_CA: top = cmp_act_a_r;
			default:                            top = CNT_MAX;
		endcase
		at_top = tick && pwm && (cnt_r == top);
		// In PWM modes a compare register equal to TOP drops its own match when the high code bit is set
		match_a = tick && !block_r && (cnt_r == cmp_act_a_r)
			&& !(pwm && code_a[1] && (cmp_act_a_r == top));
		match_b = tick && !block_r && (cnt_r == cmp_act_b_r)
			&& !(pwm && code_b[1] && (cmp_act_b_r == top));
		case (mode)
			MODE_PC_FF, MODE_PC_CA: ovf = tick && !up_r && (cnt_r == CNT_BOT);
			MODE_FAST_CA:           ovf = tick && (cnt_r == top);
			default:                ovf = tick && (cnt_r == CNT_MAX);
		endcase
		wr_en = i_write && !wait_r;

		// Counter sequence
		up_nxt  = up_r;
		cnt_nxt = cnt_r;
		if (tick) begin
			case (mode)
				MODE_CTC, MODE_FAST_FF, MODE_FAST_CA: begin
					cnt_nxt = (cnt_r == top) ? CNT_BOT : cnt_r + 8'h01;
				end
				MODE_PC_FF, MODE_PC_CA: begin
					if (up_r && (cnt_r == top)) begin
						up_nxt  = 1'b0;
						cnt_nxt = cnt_r - 8'h01;
					end else if (!up_r && (cnt_r == CNT_BOT)) begin
						up_nxt  = 1'b1;
						cnt_nxt = cnt_r + 8'h01;
					end else begin
						cnt_nxt = up_r ? cnt_r + 8'h01 : cnt_r - 8'h01;
					end
				end
				default: cnt_nxt = cnt_r + 8'h01;
			endcase
		end
		if (!pwm) begin
			up_nxt = 1'b1;
		end

		// Compare buffers load immediately outside PWM, else at TOP
		cmp_buf_a_nxt = cmp_buf_a_r;
		cmp_buf_b_nxt = cmp_buf_b_r;
		if (wr_en && (i_address == OFS_CMP_A)) begin
			cmp_buf_a_nxt = i_writedata[7:0];
		end
		if (wr_en && (i_address == OFS_CMP_B)) begin
			cmp_buf_b_nxt = i_writedata[7:0];
		end
		cmp_act_a_nxt = cmp_act_a_r;
		cmp_act_b_nxt = cmp_act_b_r;
		if (!pwm || at_top) begin
			cmp_act_a_nxt = pwm ? cmp_buf_a_r : cmp_buf_a_nxt;
			cmp_act_b_nxt = pwm ? cmp_buf_b_r : cmp_buf_b_nxt;
		end

		// Output waveforms
		// Phase correct acts at TOP only when the compare value sits at TOP
		out_a_nxt = chan_next(out_a_r, code_a, pwm, pc, clk_mode_r[WAVE_HI_BIT], up_r,
			match_a, at_top && (fast || (cmp_act_a_r == top)));
		out_b_nxt = chan_next(out_b_r, code_b, pwm, pc, 1'b0, up_r,
			match_b, at_top && (fast || (cmp_act_b_r == top)));

		// Control registers
		out_mode_nxt = out_mode_r;
		clk_mode_nxt = clk_mode_r;
		pin_ctrl_nxt = pin_ctrl_r;
		block_nxt    = block_r && !tick;
		if (wr_en) begin
			case (i_address)
				OFS_OUT_MODE: out_mode_nxt = i_writedata[7:0] & OUT_MODE_MASK;
				OFS_CLK_MODE: clk_mode_nxt = i_writedata[7:0] & CLK_MODE_MASK;
				OFS_PIN_CTRL: pin_ctrl_nxt = i_writedata[7:0] & PIN_CTRL_MASK;
				OFS_COUNTER: begin
					// A counter write wins over counting and masks any match on the next tick
					cnt_nxt   = i_writedata[7:0];
					block_nxt = 1'b1;
				end
				default: ;
			endcase
		end

		// Flags: hardware set wins over write-one clear
		flags_nxt = flags_r;
		if (wr_en && (i_address == OFS_FLAGS)) begin
			flags_nxt = flags_r & ~i_writedata[3:1];
		end
		flags_nxt[FLAG_OVF]     = flags_nxt[FLAG_OVF] | ovf;
		flags_nxt[FLAG_MATCH_A] = flags_nxt[FLAG_MATCH_A] | match_a;
		flags_nxt[FLAG_MATCH_B] = flags_nxt[FLAG_MATCH_B] | match_b;

		// Pins: compare output takes over when its mode field is nonzero
		pin_a_nxt = (out_mode_nxt[CHA_MODE_LSB +: 2] != ACT_OFF) ?
			out_a_nxt : pin_ctrl_nxt[PIN_PORT_A];
		pin_b_nxt = (out_mode_nxt[CHB_MODE_LSB +: 2] != ACT_OFF) ?
			out_b_nxt : pin_ctrl_nxt[PIN_PORT_B];

		// Bus: answer one cycle after the request, then accept it
		wait_nxt  = 1'b1;
		rdata_nxt = rdata_r;
		if ((i_read || i_write) && wait_r) begin
			wait_nxt  = 1'b0;
			if (i_read) begin
				// Read data holds between reads; a write leaves it alone
				rdata_nxt = 32'h0000_0000;
				case (i_address)
					OFS_OUT_MODE: rdata_nxt[7:0] = out_mode_r;
					OFS_CLK_MODE: rdata_nxt[7:0] = clk_mode_r;
					OFS_COUNTER:  rdata_nxt[7:0] = cnt_r;
					OFS_CMP_A:    rdata_nxt[7:0] = cmp_buf_a_r;
					OFS_CMP_B:    rdata_nxt[7:0] = cmp_buf_b_r;
					OFS_FLAGS:    rdata_nxt[3:1] = flags_r;
					OFS_PIN_CTRL: rdata_nxt[7:0] = pin_ctrl_r;
					default:      rdata_nxt      = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
		if (!rst_n_r) begin
			out_mode_r  <= REG_RESET;
			clk_mode_r  <= REG_RESET;
			cnt_r       <= REG_RESET;
			cmp_buf_a_r <= REG_RESET;
			cmp_buf_b_r <= REG_RESET;
			cmp_act_a_r <= REG_RESET;
			cmp_act_b_r <= REG_RESET;
			flags_r     <= 3'b000;
			pin_ctrl_r  <= REG_RESET;
			up_r        <= 1'b1;
			block_r     <= 1'b0;
			out_a_r     <= 1'b0;
			out_b_r     <= 1'b0;
			pin_a_r     <= 1'b0;
			pin_b_r     <= 1'b0;
			wait_r      <= 1'b1;
			rdata_r     <= 32'h0000_0000;
		end else begin
			out_mode_r  <= out_mode_nxt;
			clk_mode_r  <= clk_mode_nxt;
			cnt_r       <= cnt_nxt;
			cmp_buf_a_r <= cmp_buf_a_nxt;
			cmp_buf_b_r <= cmp_buf_b_nxt;
			cmp_act_a_r <= cmp_act_a_nxt;
			cmp_act_b_r <= cmp_act_b_nxt;
			flags_r     <= flags_nxt;
			pin_ctrl_r  <= pin_ctrl_nxt;
			up_r        <= up_nxt;
			block_r     <= block_nxt;
			out_a_r     <= out_a_nxt;
			out_b_r     <= out_b_nxt;
			pin_a_r     <= pin_a_nxt;
			pin_b_r     <= pin_b_nxt;
			wait_r      <= wait_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	assign o_readdata    = rdata_r;
	assign o_waitrequest = wait_r;
	assign o_pin_a       = pin_a_r;
	assign o_pin_b       = pin_b_r;
	// Driver follows the direction bit only
	assign o_pin_a_oe    = pin_ctrl_r[PIN_DIR_A];
	assign o_pin_b_oe    = pin_ctrl_r[PIN_DIR_B];

endmodule : timer8_waveform_mode_control

// File: timer8_wmc_chk.sv
/* Port checker for the timer block: bus handshake, read data, pin causes.
   Assumes a bind to the top module, one clock domain. */
`timescale 1ns/100ps
module timer8_wmc_chk
	import timer8_pkg::*;
(
	// Clock, reset, tick
	input wire logic        i_clk_sys,
	input wire logic        i_nrst,
	input wire logic        i_timer_tick_enable,
	// Bus
	input wire logic [4:0]  i_address,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [31:0] o_readdata,
	input wire logic        o_waitrequest,
	// Pins
	input wire logic        o_pin_a,
	input wire logic        o_pin_a_oe,
	input wire logic        o_pin_b,
	input wire logic        o_pin_b_oe
);
	// Same two-flop release as the design, so checks wake when its logic does
	logic rst_meta_r;
	logic live_r;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_r <= 1'b0;
			live_r     <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			live_r     <= rst_meta_r;
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!live_r);
	wire logic req = i_read | i_write;
	wire logic rd_ok = i_read & ~o_waitrequest;

	a_wait_answer: assert property (req && o_waitrequest |=> !o_waitrequest)
		else $error("request not answered");
	a_wait_one: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("wait low too long");
	a_wait_idle: assert property (!req |=> o_waitrequest)
		else $error("answer without request");
	a_rsv_zero: assert property (rd_ok && i_address == OFS_OUT_MODE
		|-> o_readdata[3:2] == 2'b00) else $error("reserved bits set");
	a_unmapped_zero: assert property (rd_ok && i_address[4:2] == 3'b111
		|-> o_readdata == 32'h0) else $error("unmapped read not zero");
	a_rdata_cause: assert property ($changed(o_readdata)
		|-> $past(i_read && o_waitrequest)) else $error("read data moved");
	a_pin_cause: assert property ($changed({o_pin_a, o_pin_b})
		|-> $past(i_timer_tick_enable || i_write)) else $error("pin moved");
	a_oe_cause: assert property ($changed({o_pin_a_oe, o_pin_b_oe})
		|-> $past(i_write && i_address == OFS_PIN_CTRL)) else $error("enable moved");
endmodule : timer8_wmc_chk

// File: timer8_waveform_mode_control_tb_top.sv
/* Testbench for the timer block: register rows, reset, then mode scenarios.
   Assumes the package, design and checker are compiled first. */
`timescale 1ns/100ps
module timer8_waveform_mode_control_tb_top import timer8_pkg::*;;
	typedef struct packed {logic [4:0] a; logic [7:0] w; logic [7:0] e;} row_t;
	logic        i_clk_sys = 1'b0;
	logic        i_nrst = 1'b0;
	logic        tick = 1'b0;
	logic [4:0]  i_address = 5'h00;
	logic        i_read = 1'b0;
	logic        i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [31:0] o_readdata;
	logic [31:0] q;
	logic        o_waitrequest, o_pin_a, o_pin_a_oe, o_pin_b, o_pin_b_oe;
	int          fails = 0;
	int          n_tests = 0;
	int          cyc = 0;
	row_t        rows [6] = '{'{OFS_OUT_MODE, 8'hFF, 8'hF3}, '{OFS_CLK_MODE, 8'hF8, 8'h08},
		'{OFS_CMP_A, 8'hA5, 8'hA5}, '{OFS_CMP_B, 8'h5A, 8'h5A},
		'{OFS_PIN_CTRL, 8'hFF, 8'h33}, '{5'h1C, 8'h77, 8'h00}};

	timer8_waveform_mode_control u_dut (.i_clk_sys, .i_nrst, .i_timer_tick_enable(tick),
		.i_address, .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest,
		.o_pin_a, .o_pin_a_oe, .o_pin_b, .o_pin_b_oe);

	initial forever #4 i_clk_sys = ~i_clk_sys;

	// The whole run needs well under 1000 cycles
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Wait has no local limit; the cycle ceiling cuts a hang
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		i_address <= a;
		i_writedata <= 32'(d);
		i_write <= w;
		i_read <= !w;
		do @(posedge i_clk_sys); while (o_waitrequest !== 1'b0);
		q = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
		@(posedge i_clk_sys);
	endtask : bus

	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, 32'(e));
	endtask : rd

	// Ticks back to back, one per clock, then one idle edge to let pins settle
	task automatic tk(input int n);
		tick <= 1'b1;
		repeat (n) @(posedge i_clk_sys);
		tick <= 1'b0;
		@(posedge i_clk_sys);
	endtask : tk

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		$display("test rows done");
		i_nrst <= 1'b0;
		@(posedge i_clk_sys);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		foreach (rows[i]) rd(rows[i].a, 8'h00);
		bus(1'b1, OFS_PIN_CTRL, 8'h33);
		@(posedge i_clk_sys);
		chk(32'({o_pin_a_oe, o_pin_b_oe, o_pin_a, o_pin_b}), 32'hF);
		$display("test reset done");
		// Normal: A clears and B toggles at FE, wrap sets overflow
		bus(1'b1, OFS_OUT_MODE, 8'h90);
		bus(1'b1, OFS_CMP_A, 8'hFE);
		bus(1'b1, OFS_CMP_B, 8'hFE);
		bus(1'b1, OFS_CLK_MODE, 8'h01);
		bus(1'b1, OFS_COUNTER, 8'hFC);
		tk(4);
		rd(OFS_COUNTER, 8'h00);
		rd(OFS_FLAGS, 8'h0E);
		chk(32'({o_pin_a, o_pin_b}), 32'h1);
		bus(1'b1, OFS_FLAGS, 8'h0E);
		rd(OFS_FLAGS, 8'h00);
		$display("test normal done");
		// Clear on match, TOP 4
		bus(1'b1, OFS_OUT_MODE, 8'hF2);
		bus(1'b1, OFS_CMP_A, 8'h04);
		bus(1'b1, OFS_COUNTER, 8'h00);
		tk(7);
		rd(OFS_COUNTER, 8'h02);
		rd(OFS_FLAGS, 8'h04);
		chk(32'({o_pin_a, o_pin_b}), 32'h3);
		bus(1'b1, OFS_FLAGS, 8'h0E);
		$display("test clear on match done");
		// Fast PWM, TOP 4; A matches at TOP and is ignored
		bus(1'b1, OFS_CMP_B, 8'h02);
		bus(1'b1, OFS_OUT_MODE, 8'hE3);
		bus(1'b1, OFS_CLK_MODE, 8'h09);
		bus(1'b1, OFS_COUNTER, 8'h00);
		tk(6);
		rd(OFS_COUNTER, 8'h01);
		chk(32'({o_pin_a, o_pin_b}), 32'h1);
		bus(1'b0, OFS_FLAGS, 8'h00);
		chk(32'(q[FLAG_OVF]), 32'h1);
		tk(3);
		chk(32'({o_pin_a, o_pin_b}), 32'h0);
		bus(1'b1, OFS_CMP_A, 8'h06);
		tk(1);
		rd(OFS_COUNTER, 8'h00);
		$display("test fast pwm done");
		// Phase correct, TOP 6
		bus(1'b1, OFS_OUT_MODE, 8'hA1);
		bus(1'b1, OFS_COUNTER, 8'h00);
		bus(1'b1, OFS_FLAGS, 8'h0E);
		tk(4);
		rd(OFS_COUNTER, 8'h04);
		chk(32'({o_pin_a, o_pin_b}), 32'h0);
		// Past TOP: A set by its TOP action, B waits for its down match
		tk(3);
		chk(32'({o_pin_a, o_pin_b}), 32'h2);
		tk(4);
		rd(OFS_COUNTER, 8'h01);
		chk(32'({o_pin_a, o_pin_b}), 32'h3);
		bus(1'b0, OFS_FLAGS, 8'h00);
		chk(32'(q[FLAG_OVF]), 32'h0);
		tk(2);
		bus(1'b0, OFS_FLAGS, 8'h00);
		chk(32'(q[FLAG_OVF]), 32'h1);
		$display("test phase correct done");
		// Fast PWM, TOP 6: A toggles at its match, B code 1 does nothing
		bus(1'b1, OFS_OUT_MODE, 8'h53);
		bus(1'b1, OFS_COUNTER, 8'h00);
		tk(7);
		rd(OFS_COUNTER, 8'h00);
		chk(32'({o_pin_a, o_pin_b}), 32'h1);
		$display("test pwm toggle done");
		tally_and_finish();
	end
endmodule : timer8_waveform_mode_control_tb_top

bind timer8_waveform_mode_control timer8_wmc_chk u_chk (.i_clk_sys, .i_nrst,
	.i_timer_tick_enable, .i_address, .i_read, .i_write, .i_writedata, .o_readdata,
	.o_waitrequest, .o_pin_a, .o_pin_a_oe, .o_pin_b, .o_pin_b_oe);
